// ==== design/pdpe_defines.svh ====
/*
 Register offsets, field positions, reset values and bus codes for the port D upper / port E block.
 Assumes inclusion by bare name from the block's design file.
*/
// How it works
// - Slave port read (chip select and read strobe low): upper D pins drive the latch bits as read data, ignoring direction.
// - Slave port active: upper D pins also serve as write-data inputs, ignoring direction.
// - PWM channels B, C, D drive D pins 5-7 when direction is 0, above all else.
// - PWM shutdown may float the PWM channel pins when so configured.
// - Port E is 4 bits wide; three pins are bidirectional with Schmitt inputs.
// - Port E pins selected as analog inputs read back as 0.
// - Direction 1 floats the pin driver; direction 0 drives the output latch.
// - Direction bits still act on analog pins; software keeps those pins as inputs.
// - Reset makes all three port E pins analog inputs.
// - Upper four bits of port E direction register hold slave port control and status.
// - Port E latch has its own address; read-modify-write acts on latched value.
// - Unimplemented register bits read as 0.
// - Slave port runs when mode-select bit 4 is set and PWM is single output.
// - Dual or quad PWM output disables the slave port functions.
// - In slave mode E0 is read strobe, E1 write strobe, E2 chip select.
`ifndef PDPE_DEFINES_SVH
`define PDPE_DEFINES_SVH
`define PDPE_OFF_D_LVL 8'h00
`define PDPE_OFF_D_LAT 8'h04
`define PDPE_OFF_D_DIR 8'h08
`define PDPE_OFF_E_DIR 8'h0C
`define PDPE_OFF_E_LVL 8'h10
`define PDPE_OFF_E_LAT 8'h14
`define PDPE_OFF_E_ANA 8'h18
`define PDPE_OFF_CTRL 8'h1C
`define PDPE_BIT_IBF 7
`define PDPE_BIT_OBF 6
`define PDPE_BIT_INPUT_BUFFER_OVERFLOW 5
`define PDPE_BIT_MODE 4
`define PDPE_BIT_SDTRI 0
`define PDPE_RST_D_DIR 4'hF
`define PDPE_RST_D_LAT 4'h0
`define PDPE_RST_E_DIR 3'h7
`define PDPE_RST_E_LAT 3'h0
`define PDPE_RST_E_ANA 3'h7
`define PDPE_RESP_OKAY 2'h0
`define PDPE_RESP_SLVERR 2'h2
`endif

// ==== design/pdpe_pkg.sv ====
/*
 Types shared by the port D upper / port E block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pdpe_pkg;
	typedef logic [7:0] pdpe_byte_t;
	typedef enum logic [4:0] {
		PDPE_DRV_PORT = 5'b0_0001,
		PDPE_DRV_SLRD = 5'b0_0010,
		PDPE_DRV_SLIN = 5'b0_0100,
		PDPE_DRV_PWM = 5'b0_1000,
		PDPE_DRV_HIZ = 5'b1_0000
	} pdpe_drv_e;
endpackage

// ==== design/pdpe_gpio.sv ====
/*
 Pin control for port D pins 4-7 and port E pins 0-3, with an AXI4-Lite register slave.
 Assumes the slave port handshake logic, PWM generator and analog converter sit outside;
 pins arrive asynchronously and pass two flip-flops here.
*/
`include "pdpe_defines.svh"
module pdpe_gpio
	import pdpe_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [3:0] port_d_pin_i,
	output logic [3:0] port_d_pin_o,
	output logic [3:0] port_d_pin_oe,
	input wire logic [3:0] port_e_pin_i,
	output logic [2:0] port_e_pin_o,
	output logic [2:0] port_e_pin_oe,
	input wire logic pwm_channel_b_out,
	input wire logic pwm_channel_c_out,
	input wire logic pwm_channel_d_out,
	input wire logic [2:0] pwm_pin_enable,
	input wire logic pwm_multi_output,
	input wire logic pwm_shutdown,
	input wire logic input_buffer_full,
	input wire logic output_buffer_full,
	input wire logic input_buffer_overflow_set,
	output logic slave_port_active,
	output logic slave_read_active,
	output logic slave_write_active,
	output logic [3:0] slave_write_data
);
	logic [3:0] d_sync1_reg, d_sync_reg;
	logic [3:0] e_sync1_reg, e_sync_reg;
	logic [3:0] d_lat_reg, d_dir_reg;
	logic [2:0] e_lat_reg, e_dir_reg, e_ana_reg;
	logic mode_reg, input_buffer_overflow_reg, sdtri_reg;
	logic aw_hold_reg, w_hold_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [3:0] d_o_reg, d_oe_reg;
	logic [2:0] e_o_reg, e_oe_reg;
	logic [3:0] swdata_reg;
	logic do_write, do_read, wr_hit, rd_hit;
	logic rd_strobe, cs_strobe, wr_strobe;
	logic [3:0] pwm_val, pwm_sel;
	pdpe_byte_t rd_val;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	function automatic pdpe_drv_e drive_src(input logic pwm_on, input logic dir,
		input logic sl_act, input logic sl_rd, input logic shut, input logic tri_cfg);
		if (pwm_on && !dir) begin
			drive_src = (shut && tri_cfg) ? PDPE_DRV_HIZ : PDPE_DRV_PWM;
		end else if (sl_act && sl_rd) begin
			drive_src = PDPE_DRV_SLRD;
		end else if (sl_act) begin
			drive_src = PDPE_DRV_SLIN;
		end else begin
			drive_src = dir ? PDPE_DRV_HIZ : PDPE_DRV_PORT;
		end
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = a == ADDR_W'(`PDPE_OFF_D_LVL) || a == ADDR_W'(`PDPE_OFF_D_LAT)
			|| a == ADDR_W'(`PDPE_OFF_D_DIR) || a == ADDR_W'(`PDPE_OFF_E_DIR)
			|| a == ADDR_W'(`PDPE_OFF_E_LVL) || a == ADDR_W'(`PDPE_OFF_E_LAT)
			|| a == ADDR_W'(`PDPE_OFF_E_ANA) || a == ADDR_W'(`PDPE_OFF_CTRL);
	endfunction

	// Pin synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			d_sync1_reg <= 4'h0;
			d_sync_reg <= 4'h0;
			e_sync1_reg <= 4'hF;
			e_sync_reg <= 4'hF;
		end else begin
			d_sync1_reg <= port_d_pin_i;
			d_sync_reg <= d_sync1_reg;
			e_sync1_reg <= port_e_pin_i;
			e_sync_reg <= e_sync1_reg;
		end
	end

	// Slave port gating and strobes
	assign slave_port_active = mode_reg && !pwm_multi_output;
	assign rd_strobe = !e_sync_reg[0];
	assign wr_strobe = !e_sync_reg[1];
	assign cs_strobe = !e_sync_reg[2];
	assign slave_read_active = slave_port_active && cs_strobe && rd_strobe;
	assign slave_write_active = slave_port_active && cs_strobe && wr_strobe;
	assign slave_write_data = swdata_reg;

	// Write data captured from pins in slave mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			swdata_reg <= 4'h0;
		end else if (slave_write_active) begin
			swdata_reg <= d_sync_reg;
		end
	end

	// Pin drive selection
	assign pwm_val = {pwm_channel_d_out, pwm_channel_c_out, pwm_channel_b_out, 1'b0};
	assign pwm_sel = {pwm_pin_enable, 1'b0};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			d_o_reg <= 4'h0;
			d_oe_reg <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				unique case (drive_src(pwm_sel[i], d_dir_reg[i], slave_port_active,
					slave_read_active, pwm_shutdown, sdtri_reg))
					PDPE_DRV_PWM: begin
						d_o_reg[i] <= pwm_val[i];
						d_oe_reg[i] <= 1'b1;
					end
					PDPE_DRV_SLRD: begin
						d_o_reg[i] <= d_lat_reg[i];
						d_oe_reg[i] <= 1'b1;
					end
					PDPE_DRV_SLIN: begin
						d_o_reg[i] <= d_lat_reg[i];
						d_oe_reg[i] <= 1'b0;
					end
					PDPE_DRV_PORT: begin
						d_o_reg[i] <= d_lat_reg[i];
						d_oe_reg[i] <= 1'b1;
					end
					PDPE_DRV_HIZ: begin
						d_o_reg[i] <= d_lat_reg[i];
						d_oe_reg[i] <= 1'b0;
					end
				endcase
			end
		end
	end
	assign port_d_pin_o = d_o_reg;
	assign port_d_pin_oe = d_oe_reg;

	// Port E driven by latch and direction, analog or not
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			e_o_reg <= 3'h0;
			e_oe_reg <= 3'h0;
		end else begin
			e_o_reg <= e_lat_reg;
			e_oe_reg <= ~e_dir_reg;
		end
	end
	assign port_e_pin_o = e_o_reg;
	assign port_e_pin_oe = e_oe_reg;

	// Write channel
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = !w_hold_reg && !bvalid_reg;
	assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_hit = do_write && wstrb0_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `PDPE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= is_mapped(awaddr_reg) ? `PDPE_RESP_OKAY : `PDPE_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Port D registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			d_lat_reg <= `PDPE_RST_D_LAT;
			d_dir_reg <= `PDPE_RST_D_DIR;
		end else if (wr_hit) begin
			if (awaddr_reg == ADDR_W'(`PDPE_OFF_D_LVL) || awaddr_reg == ADDR_W'(`PDPE_OFF_D_LAT)) begin
				d_lat_reg <= wdata_reg[7:4];
			end
			if (awaddr_reg == ADDR_W'(`PDPE_OFF_D_DIR)) begin
				d_dir_reg <= wdata_reg[7:4];
			end
		end
	end

	// Port E registers and slave port control
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			e_lat_reg <= `PDPE_RST_E_LAT;
			e_dir_reg <= `PDPE_RST_E_DIR;
			e_ana_reg <= `PDPE_RST_E_ANA;
			mode_reg <= 1'b0;
			sdtri_reg <= 1'b0;
		end else if (wr_hit) begin
			if (awaddr_reg == ADDR_W'(`PDPE_OFF_E_LVL) || awaddr_reg == ADDR_W'(`PDPE_OFF_E_LAT)) begin
				e_lat_reg <= wdata_reg[2:0];
			end
			if (awaddr_reg == ADDR_W'(`PDPE_OFF_E_DIR)) begin
				e_dir_reg <= wdata_reg[2:0];
				mode_reg <= wdata_reg[`PDPE_BIT_MODE];
			end
			if (awaddr_reg == ADDR_W'(`PDPE_OFF_E_ANA)) begin
				e_ana_reg <= wdata_reg[2:0];
			end
			if (awaddr_reg == ADDR_W'(`PDPE_OFF_CTRL)) begin
				sdtri_reg <= wdata_reg[`PDPE_BIT_SDTRI];
			end
		end
	end

	// Overflow flag: a new event wins over a software clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			input_buffer_overflow_reg <= 1'b0;
		end else if (input_buffer_overflow_set) begin
			input_buffer_overflow_reg <= 1'b1;
		end else if (wr_hit && awaddr_reg == ADDR_W'(`PDPE_OFF_E_DIR)) begin
			input_buffer_overflow_reg <= wdata_reg[`PDPE_BIT_INPUT_BUFFER_OVERFLOW];
		end
	end

	// Read mux
	always_comb begin
		rd_val = 8'h00;
		unique case (s_axi_araddr)
			ADDR_W'(`PDPE_OFF_D_LVL): rd_val = {d_sync_reg, 4'h0};
			ADDR_W'(`PDPE_OFF_D_LAT): rd_val = {d_lat_reg, 4'h0};
			ADDR_W'(`PDPE_OFF_D_DIR): rd_val = {d_dir_reg, 4'h0};
			ADDR_W'(`PDPE_OFF_E_DIR): rd_val = {input_buffer_full, output_buffer_full, input_buffer_overflow_reg, mode_reg,
				1'b0, e_dir_reg};
			ADDR_W'(`PDPE_OFF_E_LVL): rd_val = {4'h0, e_sync_reg[3], e_sync_reg[2:0] & ~e_ana_reg};
			ADDR_W'(`PDPE_OFF_E_LAT): rd_val = {5'h00, e_lat_reg};
			ADDR_W'(`PDPE_OFF_E_ANA): rd_val = {5'h00, e_ana_reg};
			ADDR_W'(`PDPE_OFF_CTRL): rd_val = {7'h00, sdtri_reg};
			default: rd_val = 8'h00;
		endcase
	end

	// Read channel
	assign s_axi_arready = !rvalid_reg;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_hit = is_mapped(s_axi_araddr);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `PDPE_RESP_OKAY;
		end else if (do_read) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= {24'h00_0000, rd_val};
			rresp_reg <= rd_hit ? `PDPE_RESP_OKAY : `PDPE_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Checks
	sequence seq_slave_read_pin4;
		slave_read_active && !pwm_sel[0];
	endsequence
	sequence seq_read_e_lvl;
		do_read && s_axi_araddr == ADDR_W'(`PDPE_OFF_E_LVL);
	endsequence
	sequence seq_read_e_dir;
		do_read && s_axi_araddr == ADDR_W'(`PDPE_OFF_E_DIR);
	endsequence

	chk_slave_read_drive: assert property (seq_slave_read_pin4 |=>
		port_d_pin_oe[0] && port_d_pin_o[0] == $past(d_lat_reg[0]))
		else $error("slave read does not drive latch bit");
	chk_slave_input_float: assert property (slave_port_active && !slave_read_active && !pwm_sel[0] |=>
		!port_d_pin_oe[0])
		else $error("slave port pin not released");
	chk_pwm_pin_priority: assert property (pwm_sel[1] && !d_dir_reg[1] && !(pwm_shutdown && sdtri_reg) |=>
		port_d_pin_oe[1] && port_d_pin_o[1] == $past(pwm_channel_b_out))
		else $error("pwm channel b not on pin");
	chk_pwm_shutdown_float: assert property (pwm_sel[3] && !d_dir_reg[3] && pwm_shutdown && sdtri_reg |=>
		!port_d_pin_oe[3])
		else $error("pwm pin driven during shutdown");
	chk_analog_reads_zero: assert property (seq_read_e_lvl ##0 e_ana_reg[1] |=>
		s_axi_rvalid && !s_axi_rdata[1])
		else $error("analog pin read not zero");
	chk_port_e_direction: assert property (##1 port_e_pin_oe == ~$past(e_dir_reg))
		else $error("port e enable does not follow direction");
	chk_slave_gate_multi: assert property (pwm_multi_output |=>
		port_d_pin_oe[0] == !$past(d_dir_reg[0]))
		else $error("slave port drives pin with multi output pwm");
	chk_unimpl_bits_zero: assert property (seq_read_e_dir |=>
		s_axi_rdata[3] == 1'b0 && s_axi_rdata[31:8] == 24'h00_0000)
		else $error("unimplemented bits not zero");
	chk_latch_rmw_write: assert property (wr_hit && awaddr_reg == ADDR_W'(`PDPE_OFF_E_LAT) |=>
		e_lat_reg == $past(wdata_reg[2:0]) ##1 port_e_pin_o == $past(e_lat_reg))
		else $error("port e latch write lost");
	chk_mode_enable: assert property (wr_hit && awaddr_reg == ADDR_W'(`PDPE_OFF_E_DIR) &&
		wdata_reg[`PDPE_BIT_MODE] && !pwm_multi_output ##1 !pwm_multi_output |-> slave_port_active)
		else $error("mode select did not enable slave port");
	chk_write_response: assert property (do_write |=> s_axi_bvalid)
		else $error("write response missing");
	chk_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
endmodule

// ==== testbench/pdpe_pin_model.sv ====
/*
 Board around the port pins: resolves each pin from the block's drive and the bench's drive.
 Assumes the bench never drives a pin while the block drives it.
*/
module pdpe_pin_model (
	input wire logic clk,
	input wire logic [3:0] port_d_pin_o,
	input wire logic [3:0] port_d_pin_oe,
	input wire logic [2:0] port_e_pin_o,
	input wire logic [2:0] port_e_pin_oe,
	input wire logic [3:0] ext_d_en,
	input wire logic [3:0] ext_d_val,
	input wire logic [3:0] ext_e_en,
	input wire logic [3:0] ext_e_val,
	output logic [3:0] port_d_pin_i,
	output logic [3:0] port_e_pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	bit [3:0] d_last;
	bit [3:0] e_last;
	logic [3:0] e_oe;
	logic [3:0] e_o;
	assign e_oe = {1'b0, port_e_pin_oe};
	assign e_o = {1'b0, port_e_pin_o};
	// Floating pins toggle so no stale level is read
	always_comb begin
		port_d_pin_i = (port_d_pin_oe & port_d_pin_o) | (~port_d_pin_oe & ext_d_en & ext_d_val)
			| (~port_d_pin_oe & ~ext_d_en & ~d_last);
		port_e_pin_i = (e_oe & e_o) | (~e_oe & ext_e_en & ext_e_val)
			| (~e_oe & ~ext_e_en & ~e_last);
	end
	always_ff @(posedge clk) begin
		d_last <= port_d_pin_i;
		e_last <= port_e_pin_i;
	end
endmodule

// ==== testbench/pdpe_gpio_bench.sv ====
/*
 Self-checking bench for the port pin block: register calls over AXI4-Lite and pin checks.
 Assumes the pin model stands in for the board and strobes.
*/
`include "pdpe_defines.svh"
module pdpe_gpio_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [3:0] port_d_pin_i, port_d_pin_o, port_d_pin_oe, port_e_pin_i, slave_write_data;
	logic [2:0] port_e_pin_o, port_e_pin_oe, pwm_pin_enable = 3'h0;
	logic pwm_channel_b_out = 0, pwm_channel_c_out = 0, pwm_channel_d_out = 0;
	logic pwm_multi_output = 0, pwm_shutdown = 0, input_buffer_full = 0, output_buffer_full = 0;
	logic input_buffer_overflow_set = 0, slave_port_active, slave_read_active, slave_write_active;
	logic [3:0] ext_d_en = 4'h0, ext_d_val = 4'h0, ext_e_en = 4'h8, ext_e_val = 4'h8;
	int fail_count = 0, n_compared = 0;
	pdpe_gpio i_pdpe_gpio (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .port_d_pin_i, .port_d_pin_o, .port_d_pin_oe, .port_e_pin_i, .port_e_pin_o,
		.port_e_pin_oe, .pwm_channel_b_out, .pwm_channel_c_out, .pwm_channel_d_out, .pwm_pin_enable,
		.pwm_multi_output, .pwm_shutdown, .input_buffer_full, .output_buffer_full,
		.input_buffer_overflow_set, .slave_port_active, .slave_read_active, .slave_write_active,
		.slave_write_data);
	pdpe_pin_model i_pdpe_pin_model (.clk, .port_d_pin_o, .port_d_pin_oe, .port_e_pin_o,
		.port_e_pin_oe, .ext_d_en, .ext_d_val, .ext_e_en, .ext_e_val, .port_d_pin_i, .port_e_pin_i);
	always #2 clk = ~clk;
	task automatic close_out;
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic pchk(input string n, input logic [3:0] e, input logic [3:0] g);
		chk(n, 32'(e), 32'(g));
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bh;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int k = 0; k < 50; k++) begin
			@(negedge clk);
			ah = s_axi_awvalid & s_axi_awready;
			wh = s_axi_wvalid & s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (bh) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		fail_count++;
		close_out();
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int k = 0; k < 50; k++) begin
			@(negedge clk);
			ah = s_axi_arvalid & s_axi_arready;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ah) s_axi_arvalid <= 1'b0;
			if (rh) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		fail_count++;
		close_out();
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		axr(a, rd, rr);
		chk($sformatf("reg %h", a), {24'h00_0000, e}, rd);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, rr);
	endtask
	// Pin inputs pass two flops and outputs one more
	task automatic settle;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rchk(`PDPE_OFF_D_LAT, 8'h00);
		rchk(`PDPE_OFF_D_DIR, 8'hF0);
		rchk(`PDPE_OFF_E_DIR, 8'h07);
		rchk(`PDPE_OFF_E_ANA, 8'h07);
		wr(`PDPE_OFF_D_DIR, 32'h0000_0000);
		wr(`PDPE_OFF_D_LAT, 32'hFFFF_FF5F);
		settle();
		pchk("d_oe", 4'hF, port_d_pin_oe);
		pchk("d_o", 4'h5, port_d_pin_o);
		rchk(`PDPE_OFF_D_LVL, 8'h50);
		rchk(`PDPE_OFF_D_LAT, 8'h50);
		wr(`PDPE_OFF_D_DIR, 32'h0000_00F0);
		ext_d_en <= 4'hF;
		ext_d_val <= 4'h3;
		settle();
		pchk("d_oe", 4'h0, port_d_pin_oe);
		rchk(`PDPE_OFF_D_LVL, 8'h30);
		wr(`PDPE_OFF_E_LAT, 32'h0000_00FD);
		wr(`PDPE_OFF_E_DIR, 32'h0000_0000);
		settle();
		pchk("e_oe", 4'h7, {1'b0, port_e_pin_oe});
		pchk("e_o", 4'h5, {1'b0, port_e_pin_o});
		rchk(`PDPE_OFF_E_LVL, 8'h08);
		wr(`PDPE_OFF_E_ANA, 32'h0000_0000);
		rchk(`PDPE_OFF_E_LVL, 8'h0D);
		wr(`PDPE_OFF_E_DIR, 32'h0000_0007);
		ext_e_en <= 4'hF;
		ext_e_val <= 4'hA;
		settle();
		pchk("e_oe", 4'h0, {1'b0, port_e_pin_oe});
		rchk(`PDPE_OFF_E_LVL, 8'h0A);
		rchk(`PDPE_OFF_E_LAT, 8'h05);
		ext_e_val <= 4'hF;
		wr(`PDPE_OFF_E_DIR, 32'h0000_0017);
		wr(`PDPE_OFF_D_DIR, 32'h0000_0000);
		settle();
		pchk("sl_act", 4'h1, {3'h0, slave_port_active});
		pchk("d_oe", 4'h0, port_d_pin_oe);
		@(posedge clk);
		ext_e_val <= 4'h9;
		settle();
		pchk("sl_wr", 4'h1, {3'h0, slave_write_active});
		pchk("sl_wdata", 4'h3, slave_write_data);
		@(posedge clk);
		ext_d_en <= 4'h0;
		ext_e_val <= 4'hA;
		settle();
		pchk("sl_rd", 4'h1, {3'h0, slave_read_active});
		pchk("d_oe", 4'hF, port_d_pin_oe);
		pchk("d_o", 4'h5, port_d_pin_o);
		@(posedge clk);
		input_buffer_full <= 1'b1;
		output_buffer_full <= 1'b1;
		input_buffer_overflow_set <= 1'b1;
		@(posedge clk);
		input_buffer_overflow_set <= 1'b0;
		rchk(`PDPE_OFF_E_DIR, 8'hF7);
		pwm_pin_enable <= 3'h7;
		pwm_channel_b_out <= 1'b1;
		pwm_channel_d_out <= 1'b1;
		pwm_shutdown <= 1'b1;
		settle();
		pchk("d_o", 4'hB, port_d_pin_o);
		pchk("d_oe", 4'hF, port_d_pin_oe);
		wr(`PDPE_OFF_CTRL, 32'h0000_0001);
		settle();
		pchk("d_oe", 4'h1, port_d_pin_oe);
		@(posedge clk);
		pwm_multi_output <= 1'b1;
		settle();
		pchk("sl_act", 4'h0, {3'h0, slave_port_active});
		axw(8'h20, 32'h0000_00FF, rr);
		pchk("bresp", 4'(`PDPE_RESP_SLVERR), {2'h0, rr});
		axr(8'h20, rd, rr);
		pchk("rresp", 4'(`PDPE_RESP_SLVERR), {2'h0, rr});
		chk("rdata", 32'h0000_0000, rd);
		close_out();
	end
endmodule
